// file: mmd_pkg.sv
// memory map decoder package: region codes, address bounds, register layout
// assumes a 20-bit processor address bus and byte-wide register writes
package mmd_pkg;

  localparam int ADDR_W = 20;

  // flash geometry
  localparam logic [19:0] FLASH_SMALL_TOP = 20'h01fff;
  localparam logic [19:0] FLASH_LARGE_TOP = 20'h03fff;
  localparam int BLOCK_LSB = 10;
  localparam logic [19:0] VEC_LO = 20'h00000;
  localparam logic [19:0] VEC_HI = 20'h0007f;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_LO = 20'h00080;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_HI = 20'h000bf;
  localparam logic [19:0] OPT_LO = 20'h000c0;
  localparam logic [19:0] OPT_HI = 20'h000c3;
  localparam logic [19:0] DBGID_LO = 20'h000c4;
  localparam logic [19:0] DBGID_HI = 20'h000cd;
  localparam logic [19:0] RESET_VEC = 20'h00000;

  // upper regions
  localparam logic [19:0] XSFR_LO = 20'hf0000;
  localparam logic [19:0] XSFR_HI = 20'hf07ff;
  localparam logic [19:0] MIRROR_LO = 20'hf0000;
  localparam logic [19:0] MIRROR_HI = 20'hfffff;
  localparam logic [19:0] MIRROR_MASK = 20'h03fff;
  localparam logic [19:0] RAM_LO = 20'hff900;
  localparam logic [19:0] RAM_HI = 20'hffeff;
  localparam logic [19:0] GPR_LO = 20'hffee0;
  localparam logic [19:0] GPR_HI = 20'hffeff;
  localparam logic [19:0] SFR_LO = 20'hfff00;
  localparam logic [19:0] SFR_HI = 20'hfffff;

  // mirror control register
  localparam logic [19:0] MSC_ADDR = 20'hffffe;
  localparam logic [7:0] MSC_RESET = 8'h00;
  localparam int MSC_MAA_BIT = 0;
  localparam logic RPD_RESET = 1'b0;

  typedef enum logic [3:0] {
    MMD_R_NONE = 4'h0,
    MMD_R_VECTOR = 4'h1,
    MMD_R_TABLE_CALL_INSTRUCTION = 4'h2,
    MMD_R_OPTION = 4'h3,
    MMD_R_DBGID = 4'h4,
    MMD_R_FLASH = 4'h5,
    MMD_R_MIRROR = 4'h6,
    MMD_R_RAM = 4'h7,
    MMD_R_GPR = 4'h8,
    MMD_R_SFR = 4'h9,
    MMD_R_XSFR = 4'ha,
    MMD_R_ILLEGAL = 4'hb
  } mmd_region_t;

  // one processor request
  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic [19:0] addr;
  } mmd_req_t;

  // one decoded answer
  typedef struct packed {
    mmd_region_t region;
    logic [19:0] phys;
    logic [3:0] block;
    logic hi_byte;
    logic illegal;
  } mmd_dec_t;

endpackage : mmd_pkg

// file: mmd_region_lut.sv
// combinational address classifier for the memory map decoder
// assumes the caller registers the result and supplies the mirror select bit
`timescale 1ns/1ps
`default_nettype none
module mmd_region_lut (
  input wire mmd_pkg::mmd_req_t req,
  input wire logic large_part,
  input wire logic mirror_area_select,
  output mmd_pkg::mmd_dec_t dec
);

  // inclusive range check, used for every region except flash, which compares against flash_top only
  function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  logic [19:0] a;
  logic [19:0] flash_top;
  assign a = req.addr;
  assign flash_top = large_part ? mmd_pkg::FLASH_LARGE_TOP : mmd_pkg::FLASH_SMALL_TOP;

  // priority: sfr, ram, extended sfr ahead of the mirror
  always_comb begin
    dec = '0;
    dec.phys = a;
    dec.block = a[mmd_pkg::BLOCK_LSB +: 4];
    dec.hi_byte = a[0];
    if (!req.valid) begin
      dec.region = mmd_pkg::MMD_R_NONE;
    end else if (in_rng(a, mmd_pkg::SFR_LO, mmd_pkg::SFR_HI)) begin
      dec.region = mmd_pkg::MMD_R_SFR;
    end else if (in_rng(a, mmd_pkg::GPR_LO, mmd_pkg::GPR_HI)) begin
      dec.region = mmd_pkg::MMD_R_GPR;
    end else if (in_rng(a, mmd_pkg::RAM_LO, mmd_pkg::RAM_HI)) begin
      dec.region = mmd_pkg::MMD_R_RAM;
    end else if (in_rng(a, mmd_pkg::XSFR_LO, mmd_pkg::XSFR_HI)) begin
      dec.region = mmd_pkg::MMD_R_XSFR;
    end else if (in_rng(a, mmd_pkg::MIRROR_LO, mmd_pkg::MIRROR_HI)) begin
      // mirror only on the large part, data reads, legal source select
      if (large_part && !req.fetch && !req.write && !mirror_area_select) begin
        dec.region = mmd_pkg::MMD_R_MIRROR;
        dec.phys = a & mmd_pkg::MIRROR_MASK;
        dec.block = dec.phys[mmd_pkg::BLOCK_LSB +: 4];
      end else begin
        dec.region = mmd_pkg::MMD_R_ILLEGAL;
      end
    end else if (a <= flash_top) begin
      if (in_rng(a, mmd_pkg::VEC_LO, mmd_pkg::VEC_HI)) begin
        dec.region = mmd_pkg::MMD_R_VECTOR;
      end else if (in_rng(a, mmd_pkg::TABLE_CALL_INSTRUCTION_LO, mmd_pkg::TABLE_CALL_INSTRUCTION_HI)) begin
        dec.region = mmd_pkg::MMD_R_TABLE_CALL_INSTRUCTION;
      end else if (in_rng(a, mmd_pkg::OPT_LO, mmd_pkg::OPT_HI)) begin
        dec.region = mmd_pkg::MMD_R_OPTION;
      end else if (in_rng(a, mmd_pkg::DBGID_LO, mmd_pkg::DBGID_HI)) begin
        dec.region = mmd_pkg::MMD_R_DBGID;
      end else begin
        dec.region = mmd_pkg::MMD_R_FLASH;
      end
    end else begin
      dec.region = mmd_pkg::MMD_R_ILLEGAL;
    end
    // gpr fetches never reach storage; flash writes still decode as flash
    if (req.valid && req.fetch && dec.region == mmd_pkg::MMD_R_GPR) begin
      dec.region = mmd_pkg::MMD_R_ILLEGAL;
    end
    dec.illegal = (dec.region == mmd_pkg::MMD_R_ILLEGAL);
  end

endmodule : mmd_region_lut
`default_nettype wire

// file: mmd_decoder.sv
// memory map decoder top: registered region decode plus mirror control register
// assumes the core drives one request per cycle, synchronous to sys_clk
//
// Overview of operation
// - every fetch and data access carries a 20-bit address over 1 MB
// - flash block number is address over 1 KB, blocks 00H to 0FH
// - flash ends at 01FFFH on the small part, 03FFFH on the large
// - 00000H to 0007FH is the vector table of two-byte entries
// - table words take low byte at even address, high byte at odd
// - every reset cause uses the vector slot at 0000H
// - 00080H to 000BFH holds two-byte table-call entry addresses
// - 000C0H to 000C3H decodes as option bytes
// - 000C4H to 000CDH decodes as debug security identifier
// - large part: data reads at F0000H-FFFFFH return flash by low 14 bits
// - sfr, extended sfr, ram and prohibited areas override the mirror
// - mirror answers data reads only; fetches and writes are refused
// - mirror control at FFFFEH resets to 00H, bits 7 to 1 read zero
// - mirror control accepts single-bit and full byte writes
// - ram spans FF900H to FFEFFH, for data, and for fetch below FFEE0H
// - FFEE0H to FFEFFH holds four banks of eight byte registers
// - FFF00H to FFFFFH decodes as peripheral register area
// - reset enables ram parity reset; software initialises ram first
// - F0000H to F07FFH decodes as extended peripheral area over the mirror
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic large_part,
  input wire logic req_valid,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic [19:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic req_bit_op,
  input wire logic [2:0] req_bit_sel,
  input wire logic parity_disable_wr,
  input wire logic parity_disable_val,
  output mmd_pkg::mmd_region_t dec_region,
  output logic [19:0] dec_phys_addr,
  output logic [3:0] dec_block,
  output logic dec_hi_byte,
  output logic dec_valid,
  output logic illegal_access_cause,
  output logic reset_vector_hit,
  output logic [7:0] msc_rdata,
  output logic msc_rvalid,
  output logic ram_parity_reset_disable
);

  // whole module state in one record
  typedef struct packed {
    logic [7:0] msc;
    logic rpd;
    mmd_pkg::mmd_region_t region;
    logic [19:0] phys;
    logic [3:0] block;
    logic hi_byte;
    logic valid;
    logic illegal;
    logic rst_vec;
    logic [7:0] rdata;
    logic rvalid;
  } mmd_state_t;

  mmd_state_t st_ff;
  mmd_state_t nxt_st;
  mmd_pkg::mmd_req_t req;
  mmd_pkg::mmd_dec_t dec;
  logic msc_hit;

  assign req = '{valid: req_valid, fetch: req_fetch, write: req_write, addr: req_addr};
  assign msc_hit = req_valid && !req_fetch && (req_addr == mmd_pkg::MSC_ADDR);

  mmd_region_lut u_lut (
    .req(req),
    .large_part(large_part),
    .mirror_area_select(st_ff.msc[mmd_pkg::MSC_MAA_BIT]),
    .dec(dec)
  );

  // next-state: register writes, readback and registered decode
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (msc_hit && req_write) begin
      if (req_bit_op) begin
        // bit manipulation touches one bit; only bit 0 is implemented
        if (req_bit_sel == 3'h0) begin
          nxt_st.msc[mmd_pkg::MSC_MAA_BIT] = req_wdata[0];
        end
      end else begin
        nxt_st.msc[mmd_pkg::MSC_MAA_BIT] = req_wdata[mmd_pkg::MSC_MAA_BIT];
      end
      nxt_st.msc[7:1] = 7'h00;
    end
    if (msc_hit && !req_write) begin
      nxt_st.rdata = {7'h00, st_ff.msc[mmd_pkg::MSC_MAA_BIT]};
      nxt_st.rvalid = 1'b1;
    end
    if (parity_disable_wr) begin
      nxt_st.rpd = parity_disable_val;
    end
    nxt_st.region = dec.region;
    nxt_st.phys = dec.phys;
    nxt_st.block = dec.block;
    nxt_st.hi_byte = dec.hi_byte;
    nxt_st.valid = req_valid;
    nxt_st.illegal = dec.illegal;
    nxt_st.rst_vec = req_valid && !req_write && (req_addr[19:1] == mmd_pkg::RESET_VEC[19:1]);
  end

  // synchronous reset: control state to documented defaults
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.msc <= mmd_pkg::MSC_RESET;
      st_ff.rpd <= mmd_pkg::RPD_RESET;
      st_ff.region <= mmd_pkg::MMD_R_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dec_region = st_ff.region;
  assign dec_phys_addr = st_ff.phys;
  assign dec_block = st_ff.block;
  assign dec_hi_byte = st_ff.hi_byte;
  assign dec_valid = st_ff.valid;
  assign illegal_access_cause = st_ff.illegal;
  assign reset_vector_hit = st_ff.rst_vec;
  assign msc_rdata = st_ff.rdata;
  assign msc_rvalid = st_ff.rvalid;
  assign ram_parity_reset_disable = st_ff.rpd;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_mirror_read;
    req_valid && !req_fetch && !req_write && large_part
      && req_addr >= 20'hf0800 && req_addr < 20'hff900 && !st_ff.msc[0];
  endsequence

  a_mirror_maps_flash: assert property (s_mirror_read |=> dec_region == mmd_pkg::MMD_R_MIRROR
      && dec_phys_addr == {6'h00, $past(req_addr[13:0])})
    else $error("mirror read not mapped to flash");
  a_mirror_no_fetch: assert property (req_valid && req_fetch && req_addr >= 20'hf0800
      && req_addr < 20'hff900 |=> illegal_access_cause)
    else $error("fetch from mirror not flagged");
  a_xsfr_over_mirror: assert property (req_valid && req_addr <= 20'hf07ff
      && req_addr >= 20'hf0000 |=> dec_region == mmd_pkg::MMD_R_XSFR)
    else $error("extended sfr lost to mirror");
  a_sfr_region: assert property (req_valid && req_addr >= 20'hfff00
      |=> dec_region == mmd_pkg::MMD_R_SFR)
    else $error("sfr area misdecoded");
  a_ram_region: assert property (req_valid && req_addr >= 20'hff900 && req_addr < 20'hffee0
      |=> dec_region == mmd_pkg::MMD_R_RAM)
    else $error("ram area misdecoded");
  a_gpr_no_fetch: assert property (req_valid && req_fetch && req_addr >= 20'hffee0
      && req_addr <= 20'hffeff |=> illegal_access_cause)
    else $error("register bank fetch not flagged");
  a_msc_upper_zero: assert property (msc_hit && !req_write |=> msc_rvalid
      && msc_rdata[7:1] == 7'h00 ##1 !msc_rvalid)
    else $error("mirror control upper bits not zero");
  a_block_number: assert property (req_valid && req_addr <= 20'h03fff && large_part
      |=> dec_block == $past(req_addr[13:10]))
    else $error("flash block number wrong");
  a_flash_top_small: assert property (req_valid && !large_part && req_addr >= 20'h02000
      && req_addr < 20'hf0000 |=> illegal_access_cause)
    else $error("small part beyond flash not flagged");
  a_option_area: assert property (req_valid && req_addr >= 20'h000c0 && req_addr <= 20'h000c3
      |=> dec_region == mmd_pkg::MMD_R_OPTION)
    else $error("option bytes misdecoded");
  a_parity_reset_en: assert property ($rose(rst_n) |-> !ram_parity_reset_disable)
    else $error("parity reset not enabled after reset");

endmodule : mmd_decoder
`default_nettype wire

// file: mmd_core_model.sv
// processor core model: issues fetches, reads and writes to the decoder
// assumes the decoder takes a request at each rising edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module mmd_core_model (
  input wire logic sys_clk,
  output logic req_valid,
  output logic req_fetch,
  output logic req_write,
  output logic [19:0] req_addr,
  output logic [7:0] req_wdata,
  output logic req_bit_op,
  output logic [2:0] req_bit_sel
);
  // quiet bus at time zero
  initial begin
    req_valid = 1'b0;
    req_fetch = 1'b0;
    req_write = 1'b0;
    req_addr = 20'h00000;
    req_wdata = 8'h00;
    req_bit_op = 1'b0;
    req_bit_sel = 3'h0;
  end

  // released bus shows inverted junk, not the last address
  task automatic idle();
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req_addr <= ~req_addr;
    req_wdata <= ~req_wdata;
  endtask : idle

  // one request for one cycle, back to back allowed except after a write to FFFFEH, which is followed by an idle cycle
  task automatic issue(logic f, logic w, logic [19:0] a, logic [7:0] d, logic b,
                       logic [2:0] s);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_fetch <= f;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_bit_op <= b;
    req_bit_sel <= s;
    if (w && a == 20'hffffe) idle();
  endtask : issue
endmodule : mmd_core_model
`default_nettype wire

// file: memory_map_decoder_tb.sv
// self-checking bench for the memory map decoder
// assumes mmd_decoder and mmd_core_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_tb;
  typedef struct packed {mmd_pkg::mmd_dec_t d; logic rvh;} mmd_exp_t;
  logic sys_clk, rst_n, large_part, parity_disable_wr, parity_disable_val;
  logic req_valid, req_fetch, req_write, req_bit_op;
  logic [19:0] req_addr;
  logic [7:0] req_wdata;
  logic [2:0] req_bit_sel;
  mmd_pkg::mmd_region_t dec_region;
  logic [19:0] dec_phys_addr;
  logic [3:0] dec_block;
  logic dec_hi_byte, dec_valid, illegal_access_cause, reset_vector_hit, msc_rvalid;
  logic ram_parity_reset_disable;
  logic [7:0] msc_rdata;
  int bad_count = 0;
  int cmp_count = 0;
  logic sel_shadow; // mirror select as the bench believes it
  mmd_exp_t e;
  mmd_exp_t dq[$];
  logic [7:0] mq[$];
  logic [19:0] lo [11] = '{20'h0, 20'h80, 20'hc0, 20'hc4, 20'h100, 20'h4000, 20'hf0000,
                           20'hf0800, 20'hff900, 20'hffee0, 20'hfff00};
  logic [19:0] hi [11] = '{20'h7f, 20'hbf, 20'hc3, 20'hcd, 20'h3fff, 20'hefff0, 20'hf07ff,
                           20'hff8ff, 20'hffedf, 20'hffeff, 20'hfffff};
  logic [19:0] a;

  mmd_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n), .large_part(large_part),
    .req_valid(req_valid), .req_fetch(req_fetch), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_bit_op(req_bit_op),
    .req_bit_sel(req_bit_sel), .parity_disable_wr(parity_disable_wr),
    .parity_disable_val(parity_disable_val), .dec_region(dec_region),
    .dec_phys_addr(dec_phys_addr), .dec_block(dec_block), .dec_hi_byte(dec_hi_byte),
    .dec_valid(dec_valid), .illegal_access_cause(illegal_access_cause),
    .reset_vector_hit(reset_vector_hit), .msc_rdata(msc_rdata), .msc_rvalid(msc_rvalid),
    .ram_parity_reset_disable(ram_parity_reset_disable));
  mmd_core_model core (.sys_clk(sys_clk), .req_valid(req_valid), .req_fetch(req_fetch),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_bit_op(req_bit_op), .req_bit_sel(req_bit_sel));

  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // region priority worked out independently: peripheral areas beat ram beat mirror
  function automatic mmd_exp_t expect_of(logic f, logic w, logic [19:0] ad);
    mmd_exp_t x;
    x.d.phys = ad;
    x.d.region = mmd_pkg::MMD_R_ILLEGAL;
    if (ad >= 20'hfff00) x.d.region = mmd_pkg::MMD_R_SFR;
    else if (ad >= 20'hffee0) x.d.region = f ? mmd_pkg::MMD_R_ILLEGAL : mmd_pkg::MMD_R_GPR;
    else if (ad >= 20'hff900) x.d.region = mmd_pkg::MMD_R_RAM;
    else if (ad >= 20'hf0000 && ad <= 20'hf07ff) x.d.region = mmd_pkg::MMD_R_XSFR;
    else if (ad >= 20'hf0000) begin
      if (large_part && !f && !w && !sel_shadow) begin
        x.d.region = mmd_pkg::MMD_R_MIRROR;
        x.d.phys = ad & 20'h03fff;
      end
    end
    else if (ad <= 20'h7f) x.d.region = mmd_pkg::MMD_R_VECTOR;
    else if (ad <= 20'hbf) x.d.region = mmd_pkg::MMD_R_TABLE_CALL_INSTRUCTION;
    else if (ad <= 20'hc3) x.d.region = mmd_pkg::MMD_R_OPTION;
    else if (ad <= 20'hcd) x.d.region = mmd_pkg::MMD_R_DBGID;
    else if (ad <= (large_part ? 20'h03fff : 20'h01fff)) x.d.region = mmd_pkg::MMD_R_FLASH;
    x.d.block = x.d.phys[13:10];
    x.d.hi_byte = ad[0];
    x.d.illegal = (x.d.region == mmd_pkg::MMD_R_ILLEGAL);
    x.rvh = !f && !w && ad[19:1] == 19'h0;
    return x;
  endfunction : expect_of

  // note the expectation, then hand the request to the core model
  task automatic rq(logic f, logic w, logic [19:0] ad, logic [7:0] d = 8'h00, logic b = 1'b0,
                    logic [2:0] s = 3'h0);
    if ($urandom % 4 == 0) core.idle();
    dq.push_back(expect_of(f, w, ad));
    if (!f && !w && ad == 20'hffffe) mq.push_back({7'h00, sel_shadow});
    if (w && ad == 20'hffffe && (!b || s == 3'h0)) sel_shadow = d[0];
    core.issue(f, w, ad, d, b, s);
  endtask : rq

  // output watcher: oldest note against each settled result
  always @(negedge sys_clk) begin
    if (rst_n && dec_valid === 1'b1) begin
      e = dq.pop_front();
      chk("region", dec_region, e.d.region);
      chk("illegal", illegal_access_cause, e.d.illegal);
      chk("hi_byte", dec_hi_byte, e.d.hi_byte);
      chk("reset_hit", reset_vector_hit, e.rvh);
      if (!e.d.illegal) chk("phys", dec_phys_addr, e.d.phys);
      if (!e.d.illegal) chk("block", dec_block, e.d.block);
    end
    if (rst_n && msc_rvalid === 1'b1) chk("msc_rdata", msc_rdata, mq.pop_front());
  end

  // hang guard of 4000 cycles, generous over the hundred or so cycles expected
  initial begin
    #(50 * 4000);
    bad_count++;
    end_of_test();
  end

  task automatic do_reset(logic lp);
    rst_n <= 1'b0;
    large_part <= lp;
    sel_shadow = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // main sequence
  initial begin
    void'($urandom(32'h3c3cc636));
    rst_n = 1'b0;
    large_part = 1'b1;
    parity_disable_wr = 1'b0;
    parity_disable_val = 1'b0;
    do_reset(1'b1);
    @(posedge sys_clk);
    chk("parity_dis", ram_parity_reset_disable, 1'b0);
    rq(1'b0, 1'b0, 20'hffffe);
    for (int i = 0; i < 11; i++) begin
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? lo[i] : (k == 1) ? hi[i] : lo[i] + 20'($urandom % (hi[i] - lo[i] + 1));
        rq(1'b0, 1'b0, a);
        if (i != 0 && i != 6 && i != 10) rq(1'b1, 1'b0, a);
      end
    end
    rq(1'b0, 1'b1, 20'hf1234);
    rq(1'b0, 1'b1, 20'hffd10, 8'($urandom));
    rq(1'b0, 1'b0, 20'h00001);
    rq(1'b0, 1'b1, 20'hffffe, 8'($urandom) & 8'hfe);
    rq(1'b0, 1'b0, 20'hffffe);
    rq(1'b0, 1'b1, 20'hffffe, 8'h01, 1'b1, 3'h3);
    rq(1'b0, 1'b0, 20'hffffe);
    rq(1'b0, 1'b1, 20'hffffe, 8'h01, 1'b1, 3'h0);
    rq(1'b0, 1'b0, 20'hffffe);
    rq(1'b0, 1'b0, 20'hf1234);
    rq(1'b0, 1'b1, 20'hffffe, 8'h00);
    rq(1'b0, 1'b0, 20'hffffe);
    rq(1'b0, 1'b0, 20'hfc3ff);
    core.idle();
    parity_disable_wr <= 1'b1;
    parity_disable_val <= 1'b1;
    @(posedge sys_clk);
    parity_disable_wr <= 1'b0;
    @(posedge sys_clk);
    chk("parity_dis", ram_parity_reset_disable, 1'b1);
    repeat (3) core.idle();
    do_reset(1'b0);
    rq(1'b0, 1'b0, 20'h01fff);
    rq(1'b0, 1'b0, 20'h02000);
    rq(1'b1, 1'b0, 20'h01c00);
    rq(1'b0, 1'b0, 20'hf1234);
    repeat (4) core.idle();
    chk("pending", dq.size() + mq.size(), 0);
    end_of_test();
  end
endmodule : memory_map_decoder_tb
`default_nettype wire
